//--- common/ipa_pkg.sv
// Package for the interrupt pending aggregator: register map, field layout, carrier types.
// Assumes a 32-bit APB slave with byte addresses relative to the block base.
package ipa_pkg;
  localparam logic [31:0] IPA_BLOCK_BASE = 32'h7E00_B000;
  localparam logic [11:0] IPA_OFS_BASIC_PEND = 12'h200;
  localparam logic [11:0] IPA_OFS_PEND_LOW = 12'h204;
  localparam logic [11:0] IPA_OFS_PEND_HIGH = 12'h208;
  localparam logic [11:0] IPA_OFS_FIQ_ROUTE = 12'h20C;
  localparam logic [11:0] IPA_OFS_EN_SET_LOW = 12'h210;
  localparam logic [11:0] IPA_OFS_EN_SET_HIGH = 12'h214;
  localparam logic [11:0] IPA_OFS_EN_SET_BASIC = 12'h218;
  localparam logic [11:0] IPA_OFS_EN_CLR_LOW = 12'h21C;
  localparam logic [11:0] IPA_OFS_EN_CLR_HIGH = 12'h220;
  localparam logic [11:0] IPA_OFS_EN_CLR_BASIC = 12'h224;
  localparam logic [11:0] IPA_OFS_CTRL1 = 12'h228;
  localparam logic [31:0] IPA_BASIC_PEND_RESET = 32'h0000_0000;
  localparam logic [31:0] IPA_ZERO32 = 32'h0000_0000;
  localparam logic [7:0] IPA_FIQ_RESET = 8'h00;
  localparam int IPA_FIQ_EN_BIT = 7;
  localparam int IPA_LOW_SUM_BIT = 8;
  localparam int IPA_HIGH_SUM_BIT = 9;
  localparam int IPA_MIRROR_LSB = 10;
  localparam int IPA_NUM_MIRROR = 11;
  localparam int IPA_CTRL1_HALT_SEL_BIT = 10;
  localparam int IPA_SRC_HALT0 = 4;
  localparam int IPA_SRC_HALT1 = 5;
  localparam logic [6:0] IPA_FIQ_LOCAL_BASE = 7'h40;
  localparam logic [6:0] IPA_FIQ_LOCAL_LAST = 7'h47;
  // Graphics sources mirrored into basic pending bits 10..20, ascending.
  localparam logic [63:0] IPA_MIRROR_MASK = 64'h43E0_0000_000C_0680;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } ipa_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ipa_apb_rsp_t;

  typedef struct packed {
    logic [63:0] gpu_en;
    logic [7:0] local_en;
    logic [7:0] fiq_route;
    logic [31:0] ctrl1;
    logic [63:0] gpu_s1;
    logic [63:0] gpu_s2;
    logic [7:0] local_s1;
    logic [7:0] local_s2;
    logic [31:0] basic_pend;
    logic [31:0] pend_low;
    logic [31:0] pend_high;
    ipa_apb_rsp_t rsp;
    logic irq;
    logic fiq;
  } ipa_state_t;
endpackage

//--- logic/ipa_aggregator.sv
// Interrupt pending aggregator: gathers 64 graphics lines and eight local lines into pending registers.
// Assumes an APB master on clk_sys and asynchronous interrupt lines, synchronised here.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps

// Contract
// R1: No vector; three pending registers instead.
// R2: Two graphics pending registers, one bit each.
// R3: Basic bits 8/9 summarise low/high graphics.
// R4: Summaries exclude mirrored graphics sources.
// R5: Bits 10-20 mirror eleven graphics sources.
// R6: Bits 0-7 show the local sources.
// R7: Control bit 10 swaps halt source.
// R8: Basic pending read-only at 0x200, resets zero.
// R9: One selectable fast route with enable.
// R10: Software clears normal enable of fast source.
// R11: No priority among sources.
// R12: Software polls pending registers.
// R13: Registers at 0x200 to 0x224 in words; the control word is also mapped, at 0x228.
// R14: Software leaves unlisted graphics sources disabled.
// R15: Interrupts are level sensitive.
// R16: Write one to set register enables.
// R17: Only enabled sources appear pending.
// R18: Write one to clear register disables.
// R19: Normal interrupt while anything enabled pends.
module ipa_aggregator
  import ipa_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire ipa_apb_req_t apb_req,
  output ipa_apb_rsp_t apb_rsp,
  input wire logic [63:0] gpu_irq_in,
  input wire logic [7:0] local_irq_in,
  output logic irq_out,
  output logic fiq_out
);

  ipa_state_t s_q;
  ipa_state_t s_d;

  logic [63:0] gpu_vis;
  logic [7:0] local_src;
  logic [7:0] local_vis;
  logic [31:0] basic_v;
  logic [10:0] mirror_v;
  logic fiq_sel;
  logic wr_acc;
  logic rd_acc;
  int k;

  // Returns true when an offset is one of the mapped words.
  function automatic logic ipa_mapped(input logic [11:0] a);
    ipa_mapped = (a >= IPA_OFS_BASIC_PEND) && (a <= IPA_OFS_CTRL1) && (a[1:0] == 2'b00);
  endfunction

  // ****************************************
  // Pending view
  // ****************************************
  always_comb begin
    local_src = s_q.local_s2;
    // The halt position can report core 1 so a fast handler sees either core.
    if (s_q.ctrl1[IPA_CTRL1_HALT_SEL_BIT]) begin // R7
      local_src[IPA_SRC_HALT0] = s_q.local_s2[IPA_SRC_HALT1];
    end
    gpu_vis = s_q.gpu_s2 & s_q.gpu_en; // R17 R15 R2
    local_vis = local_src & s_q.local_en; // R17
    k = 0;
    mirror_v = '0;
    for (int i = 0; i < 64; i++) begin
      if (IPA_MIRROR_MASK[i]) begin // R5
        mirror_v[k[3:0]] = gpu_vis[i];
        k = k + 1;
      end
    end
    basic_v = IPA_ZERO32;
    basic_v[7:0] = local_vis; // R6
    basic_v[IPA_LOW_SUM_BIT] = |(gpu_vis[31:0] & ~IPA_MIRROR_MASK[31:0]); // R3 R4
    basic_v[IPA_HIGH_SUM_BIT] = |(gpu_vis[63:32] & ~IPA_MIRROR_MASK[63:32]); // R3 R4
    basic_v[IPA_MIRROR_LSB +: IPA_NUM_MIRROR] = mirror_v; // R5
    // Fast route looks at the raw level, not the normal enable.
    if (s_q.fiq_route[6:0] < IPA_FIQ_LOCAL_BASE) begin
      fiq_sel = s_q.gpu_s2[s_q.fiq_route[5:0]];
    end else if (s_q.fiq_route[6:0] <= IPA_FIQ_LOCAL_LAST) begin
      fiq_sel = local_src[s_q.fiq_route[2:0]];
    end else begin
      fiq_sel = 1'b0;
    end
  end

  assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_acc = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

  // ****************************************
  // State update
  // ****************************************
  always_comb begin
    s_d = s_q;
    if (clk_en) begin
      s_d.gpu_s1 = gpu_irq_in;
      s_d.gpu_s2 = s_q.gpu_s1;
      s_d.local_s1 = local_irq_in;
      s_d.local_s2 = s_q.local_s1;
      s_d.basic_pend = basic_v; // R1 R11
      s_d.pend_low = gpu_vis[31:0]; // R2
      s_d.pend_high = gpu_vis[63:32]; // R2
      s_d.irq = |gpu_vis || |local_vis; // R19 R15
      s_d.fiq = s_q.fiq_route[IPA_FIQ_EN_BIT] && fiq_sel; // R9
      // Every access takes exactly one access cycle; pready is registered from the setup cycle, so it is high in the access cycle.
      s_d.rsp.pready = apb_req.psel && !apb_req.penable;
      s_d.rsp.pslverr = apb_req.psel && !apb_req.penable && !ipa_mapped(apb_req.paddr);
      if (rd_acc) begin
        unique case (apb_req.paddr)
          IPA_OFS_BASIC_PEND: s_d.rsp.prdata = s_q.basic_pend; // R8
          IPA_OFS_PEND_LOW: s_d.rsp.prdata = s_q.pend_low;
          IPA_OFS_PEND_HIGH: s_d.rsp.prdata = s_q.pend_high;
          IPA_OFS_FIQ_ROUTE: s_d.rsp.prdata = {24'h00_0000, s_q.fiq_route};
          IPA_OFS_EN_SET_LOW, IPA_OFS_EN_CLR_LOW: s_d.rsp.prdata = s_q.gpu_en[31:0];
          IPA_OFS_EN_SET_HIGH, IPA_OFS_EN_CLR_HIGH: s_d.rsp.prdata = s_q.gpu_en[63:32];
          IPA_OFS_EN_SET_BASIC, IPA_OFS_EN_CLR_BASIC: s_d.rsp.prdata = {24'h00_0000, s_q.local_en};
          IPA_OFS_CTRL1: s_d.rsp.prdata = s_q.ctrl1;
          default: s_d.rsp.prdata = IPA_ZERO32;
        endcase
      end
      if (wr_acc) begin
        unique case (apb_req.paddr) // R13
          IPA_OFS_FIQ_ROUTE: s_d.fiq_route = apb_req.pwdata[7:0];
          IPA_OFS_EN_SET_LOW: s_d.gpu_en[31:0] = s_q.gpu_en[31:0] | apb_req.pwdata; // R16
          IPA_OFS_EN_SET_HIGH: s_d.gpu_en[63:32] = s_q.gpu_en[63:32] | apb_req.pwdata; // R16
          IPA_OFS_EN_SET_BASIC: s_d.local_en = s_q.local_en | apb_req.pwdata[7:0]; // R16
          IPA_OFS_EN_CLR_LOW: s_d.gpu_en[31:0] = s_q.gpu_en[31:0] & ~apb_req.pwdata; // R18
          IPA_OFS_EN_CLR_HIGH: s_d.gpu_en[63:32] = s_q.gpu_en[63:32] & ~apb_req.pwdata; // R18
          IPA_OFS_EN_CLR_BASIC: s_d.local_en = s_q.local_en & ~apb_req.pwdata[7:0]; // R18
          IPA_OFS_CTRL1: s_d.ctrl1 = apb_req.pwdata;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
      s_q.basic_pend <= IPA_BASIC_PEND_RESET; // R8
      s_q.fiq_route <= IPA_FIQ_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign apb_rsp = s_q.rsp;
  assign irq_out = s_q.irq;
  assign fiq_out = s_q.fiq;

  // ****************************************
  // Checks
  // ****************************************
  property p_basic_ro;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && wr_acc && apb_req.paddr == IPA_OFS_BASIC_PEND) |=> (s_q.gpu_en == $past(s_q.gpu_en));
  endproperty
  a_basic_ro: assert property (p_basic_ro) else $error("basic pending write changed state"); // R8

  property p_set;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && wr_acc && apb_req.paddr == IPA_OFS_EN_SET_LOW) |=>
        (s_q.gpu_en[31:0] == ($past(s_q.gpu_en[31:0]) | $past(apb_req.pwdata)));
  endproperty
  a_set: assert property (p_set) else $error("enable set wrong"); // R16

  property p_clr;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && wr_acc && apb_req.paddr == IPA_OFS_EN_CLR_HIGH) |=>
        (s_q.gpu_en[63:32] == ($past(s_q.gpu_en[63:32]) & ~$past(apb_req.pwdata)));
  endproperty
  a_clr: assert property (p_clr) else $error("enable clear wrong"); // R18

  property p_masked;
    @(posedge clk_sys) disable iff (rst)
      clk_en |=> ((s_q.pend_low & ~$past(s_q.gpu_en[31:0])) == IPA_ZERO32);
  endproperty
  a_masked: assert property (p_masked) else $error("disabled source visible"); // R17

  property p_sum;
    @(posedge clk_sys) disable iff (rst)
      clk_en |=> (s_q.basic_pend[IPA_LOW_SUM_BIT] == |($past(gpu_vis[31:0]) & ~IPA_MIRROR_MASK[31:0]));
  endproperty
  a_sum: assert property (p_sum) else $error("low summary wrong"); // R3

  property p_mirror62;
    @(posedge clk_sys) disable iff (rst)
      clk_en |=> (s_q.basic_pend[20] == $past(gpu_vis[62]) && s_q.basic_pend[31:21] == 11'h000);
  endproperty
  a_mirror62: assert property (p_mirror62) else $error("mirror bit 20 wrong"); // R5

  // The level and the pending words load on the same edge, so they are compared in the same cycle.
  property p_irq;
    @(posedge clk_sys) disable iff (rst)
      clk_en |=> (irq_out == (|s_q.basic_pend[7:0] || |s_q.pend_low || |s_q.pend_high));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch"); // R19

  property p_fiq_off;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && !s_q.fiq_route[IPA_FIQ_EN_BIT]) |=> !fiq_out;
  endproperty
  a_fiq_off: assert property (p_fiq_off) else $error("fiq without enable"); // R9

  property p_halt;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && s_q.ctrl1[IPA_CTRL1_HALT_SEL_BIT] && s_q.local_en[IPA_SRC_HALT0]) |=>
        (s_q.basic_pend[IPA_SRC_HALT0] == $past(s_q.local_s2[IPA_SRC_HALT1]));
  endproperty
  a_halt: assert property (p_halt) else $error("halt swap wrong"); // R7

  // ****************************************
  // Further checks on views, enables and bus
  // ****************************************
  // The pending-word, local-view and halt checks repeat the datapath from the raw synchroniser stages, so a fault in the
  // shared pending view shows up in them even where the checks above agree with it.
  property p_sum_high;
    @(posedge clk_sys) disable iff (rst)
      clk_en |=> (s_q.basic_pend[IPA_HIGH_SUM_BIT] == |($past(gpu_vis[63:32]) & ~IPA_MIRROR_MASK[63:32]));
  endproperty
  a_sum_high: assert property (p_sum_high) else $error("high summary wrong"); // R3 R4

  property p_masked_high;
    @(posedge clk_sys) disable iff (rst)
      clk_en |=> ((s_q.pend_high & ~$past(s_q.gpu_en[63:32])) == IPA_ZERO32);
  endproperty
  a_masked_high: assert property (p_masked_high) else $error("disabled high source visible"); // R17

  property p_masked_local;
    @(posedge clk_sys) disable iff (rst)
      clk_en |=> ((s_q.basic_pend[7:0] & ~$past(s_q.local_en)) == IPA_FIQ_RESET);
  endproperty
  a_masked_local: assert property (p_masked_local) else $error("disabled local source visible"); // R17

  property p_pend_low;
    @(posedge clk_sys) disable iff (rst)
      clk_en |=> (s_q.pend_low == $past(s_q.gpu_s2[31:0] & s_q.gpu_en[31:0]));
  endproperty
  a_pend_low: assert property (p_pend_low) else $error("low pending word wrong"); // R2

  property p_pend_high;
    @(posedge clk_sys) disable iff (rst)
      clk_en |=> (s_q.pend_high == $past(s_q.gpu_s2[63:32] & s_q.gpu_en[63:32]));
  endproperty
  a_pend_high: assert property (p_pend_high) else $error("high pending word wrong"); // R2

  property p_local_view;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && !s_q.ctrl1[IPA_CTRL1_HALT_SEL_BIT]) |=>
        (s_q.basic_pend[7:0] == $past(s_q.local_s2 & s_q.local_en));
  endproperty
  a_local_view: assert property (p_local_view) else $error("local view wrong"); // R6

  property p_halt_plain;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && !s_q.ctrl1[IPA_CTRL1_HALT_SEL_BIT]) |=>
        (s_q.basic_pend[IPA_SRC_HALT0] == $past(s_q.local_s2[IPA_SRC_HALT0] && s_q.local_en[IPA_SRC_HALT0]));
  endproperty
  a_halt_plain: assert property (p_halt_plain) else $error("halt without swap wrong"); // R7

  property p_set_high;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && wr_acc && apb_req.paddr == IPA_OFS_EN_SET_HIGH) |=>
        (s_q.gpu_en[63:32] == ($past(s_q.gpu_en[63:32]) | $past(apb_req.pwdata)));
  endproperty
  a_set_high: assert property (p_set_high) else $error("high enable set wrong"); // R16

  property p_set_basic;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && wr_acc && apb_req.paddr == IPA_OFS_EN_SET_BASIC) |=>
        (s_q.local_en == ($past(s_q.local_en) | $past(apb_req.pwdata[7:0])));
  endproperty
  a_set_basic: assert property (p_set_basic) else $error("local enable set wrong"); // R16

  property p_clr_low;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && wr_acc && apb_req.paddr == IPA_OFS_EN_CLR_LOW) |=>
        (s_q.gpu_en[31:0] == ($past(s_q.gpu_en[31:0]) & ~$past(apb_req.pwdata)));
  endproperty
  a_clr_low: assert property (p_clr_low) else $error("low enable clear wrong"); // R18

  property p_clr_basic;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && wr_acc && apb_req.paddr == IPA_OFS_EN_CLR_BASIC) |=>
        (s_q.local_en == ($past(s_q.local_en) & ~$past(apb_req.pwdata[7:0])));
  endproperty
  a_clr_basic: assert property (p_clr_basic) else $error("local enable clear wrong"); // R18

  // The fast route taps the synchronised level ahead of the normal enables.
  property p_fiq_gpu;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && s_q.fiq_route[IPA_FIQ_EN_BIT] && s_q.fiq_route[6:0] < IPA_FIQ_LOCAL_BASE) |=>
        (fiq_out == $past(s_q.gpu_s2[s_q.fiq_route[5:0]]));
  endproperty
  a_fiq_gpu: assert property (p_fiq_gpu) else $error("fast route from graphics wrong"); // R9

  property p_level_on;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && (|gpu_vis || |local_vis)) |=> irq_out;
  endproperty
  a_level_on: assert property (p_level_on) else $error("irq dropped while source pends"); // R15

  property p_level_off;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && !(|gpu_vis || |local_vis)) |=> !irq_out;
  endproperty
  a_level_off: assert property (p_level_off) else $error("irq without pending source"); // R19

  property p_pready;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && apb_req.psel && !apb_req.penable) |=> apb_rsp.pready;
  endproperty
  a_pready: assert property (p_pready) else $error("no ready in access cycle"); // R13

  property p_pready_one;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && apb_rsp.pready && apb_req.penable) |=> !apb_rsp.pready;
  endproperty
  a_pready_one: assert property (p_pready_one) else $error("ready held too long"); // R13

  property p_err_unmapped;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && apb_req.psel && !apb_req.penable && !ipa_mapped(apb_req.paddr)) |=> apb_rsp.pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not flagged"); // R13

  c_irq: cover property (@(posedge clk_sys) disable iff (rst) $rose(irq_out));
  c_fiq: cover property (@(posedge clk_sys) disable iff (rst) $rose(fiq_out));
  c_sum: cover property (@(posedge clk_sys) disable iff (rst) s_q.basic_pend[IPA_HIGH_SUM_BIT]);
  c_err: cover property (@(posedge clk_sys) disable iff (rst) apb_rsp.pslverr);
  c_swap: cover property (@(posedge clk_sys) disable iff (rst) s_q.ctrl1[IPA_CTRL1_HALT_SEL_BIT] && fiq_out);
endmodule

//--- tb/ipa_core_model.sv
// Processor-side intake model: watches the normal and fast interrupt levels.
// Assumes both levels are registered outputs on clk_sys.
`timescale 1ns/1ps
module ipa_core_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic irq_out,
  input wire logic fiq_out,
  output int both_cnt_q
);
  // Software keeps a fast source out of the normal enables, so any overlap is counted as a breach.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      both_cnt_q <= 0;
    end else if (irq_out && fiq_out) begin
      both_cnt_q <= both_cnt_q + 1;
    end
  end
endmodule

//--- tb/irq_pending_aggregator_tb_top.sv
// Self-checking bench for the interrupt pending aggregator.
// Assumes an APB slave answering in one access cycle and a three-edge input latency.
`timescale 1ns/1ps
module irq_pending_aggregator_tb_top;
  import ipa_pkg::*;
  `define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  ipa_apb_req_t req = '0;
  ipa_apb_rsp_t rsp;
  logic [63:0] gpu = 64'h0;
  logic [7:0] loc = 8'h00;
  logic ce = 1'b1;
  logic irq;
  logic fiq;
  int both_cnt;
  int fails = 0;
  int samples_checked = 0;
  logic [31:0] rd_v;
  logic err_v;

  always #12.5 clk_sys = ~clk_sys;

  ipa_aggregator dut (.clk_sys(clk_sys), .rst(rst), .clk_en(ce), .apb_req(req), .apb_rsp(rsp),
    .gpu_irq_in(gpu), .local_irq_in(loc), .irq_out(irq), .fiq_out(fiq));
  ipa_core_model core (.clk_sys(clk_sys), .rst(rst), .irq_out(irq), .fiq_out(fiq), .both_cnt_q(both_cnt));

  // ****************************************
  // Bus and stimulus helpers
  // ****************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rd_v = rsp.prdata;
    err_v = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd_v, e)
  endtask

  // Three edges of latency are fixed for the input path; one spare edge is allowed.
  task automatic drive(input logic [63:0] g, input logic [7:0] l);
    @(posedge clk_sys);
    gpu <= g;
    loc <= l;
    repeat (4) @(posedge clk_sys);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_map();
    rd(IPA_OFS_BASIC_PEND, 32'h0000_0000);
    rd(IPA_OFS_FIQ_ROUTE, 32'h0000_0000);
    rd(12'h300, 32'h0000_0000);
    `CHK(err_v, 1'b1)
    wr(IPA_OFS_BASIC_PEND, 32'hFFFF_FFFF);
    rd(IPA_OFS_BASIC_PEND, 32'h0000_0000);
  endtask

  task automatic t_enables();
    wr(IPA_OFS_EN_SET_LOW, 32'hFFFF_FFFF);
    wr(IPA_OFS_EN_CLR_LOW, 32'h0000_FFFF);
    rd(IPA_OFS_EN_SET_LOW, 32'hFFFF_0000);
    wr(IPA_OFS_EN_SET_LOW, 32'h0000_0088);
    rd(IPA_OFS_EN_CLR_LOW, 32'hFFFF_0088);
    wr(IPA_OFS_EN_SET_HIGH, 32'hFFFF_FFFF);
    wr(IPA_OFS_EN_SET_BASIC, 32'h0000_00FF);
  endtask

  task automatic t_pending();
    drive(64'h4000_0100_0000_0088, 8'h01);
    rd(IPA_OFS_BASIC_PEND, 32'h0010_0701);
    rd(IPA_OFS_PEND_LOW, 32'h0000_0088);
    rd(IPA_OFS_PEND_HIGH, 32'h4000_0100);
    `CHK(irq, 1'b1)
    drive(64'h4000_0000_0000_0080, 8'h00);
    rd(IPA_OFS_BASIC_PEND, 32'h0010_0400);
    drive(64'h0000_0000_0000_0200, 8'h00);
    rd(IPA_OFS_PEND_LOW, 32'h0000_0000);
    `CHK(irq, 1'b0)
    drive(64'h0000_0000_0000_0080, 8'h00);
    repeat (10) @(posedge clk_sys);
    `CHK(irq, 1'b1)
    wr(IPA_OFS_EN_CLR_LOW, 32'h0000_0080);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b0)
  endtask

  task automatic t_local();
    for (int i = 0; i < 8; i++) begin
      drive(64'h0, 8'h01 << i);
      rd(IPA_OFS_BASIC_PEND, 32'h0000_0001 << i);
    end
    drive(64'h0, 8'h20);
    wr(IPA_OFS_CTRL1, 32'h0000_0400);
    rd(IPA_OFS_BASIC_PEND, 32'h0000_0030);
    wr(IPA_OFS_EN_CLR_BASIC, 32'h0000_0030);
    wr(IPA_OFS_FIQ_ROUTE, 32'h0000_00C4);
    repeat (2) @(posedge clk_sys);
    `CHK(fiq, 1'b1)
    wr(IPA_OFS_CTRL1, 32'h0000_0000);
    drive(64'h0, 8'h00);
  endtask

  task automatic t_fast();
    wr(IPA_OFS_FIQ_ROUTE, 32'h0000_0087);
    drive(64'h0000_0000_0000_0080, 8'h00);
    `CHK(fiq, 1'b1)
    `CHK(irq, 1'b0)
    rd(IPA_OFS_FIQ_ROUTE, 32'h0000_0087);
    wr(IPA_OFS_FIQ_ROUTE, 32'h0000_0007);
    repeat (2) @(posedge clk_sys);
    `CHK(fiq, 1'b0)
    `CHK(both_cnt, 0)
  endtask

  // A low clock enable must freeze the input path and the interrupt level.
  task automatic t_freeze();
    @(posedge clk_sys);
    ce <= 1'b0;
    loc <= 8'h01;
    repeat (6) @(posedge clk_sys);
    `CHK(irq, 1'b0)
    ce <= 1'b1;
    repeat (4) @(posedge clk_sys);
    `CHK(irq, 1'b1)
    drive(64'h0, 8'h00);
  endtask

  task automatic complete_run();
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset_map();
    t_enables();
    t_pending();
    t_local();
    t_fast();
    t_freeze();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    complete_run();
  end
endmodule
